// file: logic/dac_consts.svh
// constants for the door access and alarm control block
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH
`define DAC_CLK_HZ 20000000
`define DAC_MS_HZ 1000
`define DAC_MS_CYCLES (`DAC_CLK_HZ / `DAC_MS_HZ)
`define DAC_SEC_MS 1000
`define DAC_IDS_STEP_MS 100
`define DAC_BEEP_HALF_MS 250
`define DAC_RELEASE_RST 8'h07
`define DAC_AJAR_RST 8'h14
`define DAC_EMLEN_RST 2'h2
`define DAC_REASON_EXT 8'hFF
`define DAC_EM_W 40
`define DAC_HID_W 45
`endif

// file: logic/dac_pkg.sv
// types for the door access and alarm control block
package dac_pkg;
  typedef enum logic [1:0] {
    DAC_STD = 2'h0,
    DAC_TOG = 2'h1,
    DAC_PUL = 2'h2
  } dac_relay_e;
  typedef enum logic [1:0] {
    DAC_WG_STD = 2'h0,
    DAC_WG_ENTRY = 2'h1,
    DAC_WG_IDS = 2'h2
  } dac_wmode_e;
endpackage : dac_pkg

// file: logic/dac_tick.sv
// tick divider: one-cycle enables per millisecond and per second
`timescale 1ns/1ps
`include "dac_consts.svh"
module dac_tick (
  input wire logic core_clk,
  input wire logic rstn,
  output logic ms_tick,
  output logic sec_tick
);
  logic [15:0] cyc; // cycles within a millisecond
  logic [9:0] msc; // milliseconds within a second
  wire ms_wrap = (cyc == 16'(`DAC_MS_CYCLES - 1));
  wire sec_wrap = ms_wrap && (msc == 10'(`DAC_SEC_MS - 1));
  // free running dividers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cyc <= 16'h0000;
      msc <= 10'h000;
      ms_tick <= 1'b0;
      sec_tick <= 1'b0;
    end else begin
      cyc <= ms_wrap ? 16'h0000 : cyc + 16'h0001;
      if (ms_wrap) msc <= (msc == 10'(`DAC_SEC_MS - 1)) ? 10'h000 : msc + 10'h001;
      ms_tick <= ms_wrap;
      sec_tick <= sec_wrap;
    end
  end
endmodule : dac_tick

// file: logic/dac_ctrl.sv
// door access and alarm control top
`timescale 1ns/1ps
`include "dac_consts.svh"
module dac_ctrl #(
  parameter int EM_W = `DAC_EM_W,
  parameter int HID_W = `DAC_HID_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  // configuration
  input wire logic [1:0] relay_style, // dac_relay_e code
  input wire logic [7:0] release_time, // seconds
  input wire logic [15:0] pulse_width_ms,
  input wire logic beep_on_release,
  input wire logic exit_enable,
  input wire logic sched_enable,
  input wire logic sched_valid,
  input wire logic [1:0] second_input_mode, // 0 no effect,1 handle,2 tamper,3 off
  input wire logic third_input_tamper,
  input wire logic [7:0] ajar_time,
  input wire logic [7:0] sig_time_tamper,
  input wire logic [7:0] sig_time_forced,
  input wire logic [7:0] sig_time_ajar,
  input wire logic [7:0] sig_time_apb,
  input wire logic [7:0] sig_time_card,
  input wire logic [1:0] em_len_sel, // 0:24 1:32 2:40
  input wire logic [1:0] wg_mode, // dac_wmode_e code
  input wire logic ids_pulse_mode,
  input wire logic [7:0] ids_pulse_steps, // 100 ms steps
  input wire logic ids_request,
  input wire logic [7:0] key_code,
  // events and inputs
  input wire logic cred_valid, // one-cycle: valid credential
  input wire logic cred_invalid,
  input wire logic cred_ext, // read came from external reader
  input wire logic cred_alarm_flag,
  input wire logic cred_duress,
  input wire logic apb_time_block,
  input wire logic apb_zone_block,
  input wire logic host_open,
  input wire logic exit_button,
  input wire logic door_open,
  input wire logic second_input,
  input wire logic third_input,
  input wire logic optical_tamper,
  input wire logic [EM_W-1:0] em_code_in,
  input wire logic hid_tech,
  input wire logic [HID_W-1:0] hid_raw,
  input wire logic [5:0] hid_len, // recognised length
  // outputs
  output logic lock_release,
  output logic beeper,
  output logic alarm_out,
  output logic [4:0] alarm_status, // tamper,forced,ajar,apb,card
  output logic invalid_signal,
  output logic [7:0] reason_code,
  output logic [HID_W-1:0] cred_code,
  output logic host_report, // pulse: read reported
  output logic ext_buzzer,
  output logic intrusion_system,
  output logic cfg_conflict
);
  logic ms_tick;
  logic sec_tick;
  logic [7:0] rel_cnt; // release seconds left
  logic [15:0] pulse_cnt;
  logic toggle_state;
  logic open_beep; // release tone until door opens or release ends
  logic door_q;
  logic [7:0] ajar_cnt;
  logic [7:0] sig_cnt [5]; // per-class signalling seconds
  logic [4:0] alarm; // sticky alarm conditions
  logic [4:0] beep_act; // acoustic signalling active per class
  logic armed; // tamper armed
  logic tamp_seen_q;
  logic [8:0] blink;
  logic [15:0] ids_cnt;
  logic inv_cnt;

  dac_tick dac_tick_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .ms_tick(ms_tick),
    .sec_tick(sec_tick)
  );

  // decode
  wire st_std = (relay_style == dac_pkg::DAC_STD);
  wire st_tog = (relay_style == dac_pkg::DAC_TOG);
  wire st_pul = (relay_style == dac_pkg::DAC_PUL);
  wire perm = sched_enable && sched_valid && !st_tog;
  wire conflict = sched_enable && st_tog;
  wire handle_act = (second_input_mode == 2'h1) && second_input;
  wire exit_req = exit_enable && exit_button
    && (second_input_mode == 2'h0 ? 1'b1 : 1'b1);
  wire open_act = cred_valid || exit_req || host_open;
  wire door_rise = door_open && !door_q;
  wire releasing = (rel_cnt != 8'h00);
  wire tamp_src = optical_tamper
    || ((second_input_mode == 2'h2) && second_input)
    || (third_input_tamper && third_input);
  wire tamper_ev = armed && tamp_src;
  wire forced_ev = door_rise && !releasing && !perm && !handle_act
    && !(st_tog && toggle_state);
  wire ajar_ev = door_open && sec_tick && ajar_cnt == 8'h01;
  wire apb_ev = (cred_valid || cred_invalid) && (apb_time_block || apb_zone_block);
  wire card_ev = cred_valid && (cred_alarm_flag || cred_duress);
  wire [4:0] alarm_ev = {tamper_ev, forced_ev, ajar_ev, apb_ev, card_ev};
  wire [7:0] sig_time [5];
  assign sig_time[4] = sig_time_tamper;
  assign sig_time[3] = sig_time_forced;
  assign sig_time[2] = sig_time_ajar;
  assign sig_time[1] = sig_time_apb;
  assign sig_time[0] = sig_time_card;
  wire [4:0] alarm_clr = {!tamp_src, !door_open && !forced_ev, !door_open,
    1'b0, 1'b0}; // conditions end
  wire any_read = cred_valid || cred_invalid;
  wire steady = beep_act[4];
  wire inter = |beep_act[3:1] && blink[8];
  wire next_beeper = (steady || inter || open_beep) && !inv_cnt;
  wire [4:0] out_mask = 5'b11101; // apb not on alarm output
  wire next_alarm_out = |(alarm & out_mask & {sig_time[4] != 8'h00,
    sig_time[3] != 8'h00, sig_time[2] != 8'h00, 1'b1, sig_time[0] != 8'h00});
  wire [HID_W-1:0] em_trunc = (em_len_sel == 2'h0) ? HID_W'(em_code_in[23:0]) :
    (em_len_sel == 2'h1) ? HID_W'(em_code_in[31:0]) : HID_W'(em_code_in);
  wire [HID_W-1:0] hid_fmt = (hid_len == 6'h1A) ? HID_W'(hid_raw[25:0]) :
    (hid_len == 6'h20) ? HID_W'(hid_raw[31:0]) : hid_raw;
  wire entry = (wg_mode == dac_pkg::DAC_WG_ENTRY);
  wire ids_mode = (wg_mode == dac_pkg::DAC_WG_IDS);
  wire next_lock = perm || (st_std && releasing) || (st_tog && toggle_state)
    || (st_pul && pulse_cnt != 16'h0000);

  // release timer and relay state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rel_cnt <= 8'h00;
      pulse_cnt <= 16'h0000;
      toggle_state <= 1'b0;
      open_beep <= 1'b0;
      door_q <= 1'b0;
    end else begin
      door_q <= door_open;
      if (open_act) begin
        rel_cnt <= release_time; // restart full value
        open_beep <= beep_on_release && !perm;
        if (st_tog) toggle_state <= !toggle_state;
        if (st_pul) pulse_cnt <= pulse_width_ms;
      end else begin
        if (door_rise) begin
          open_beep <= 1'b0;
          if (st_std) rel_cnt <= 8'h00;
        end else if (sec_tick && releasing) begin
          rel_cnt <= rel_cnt - 8'h01;
        end
        if (sec_tick && rel_cnt == 8'h01) open_beep <= 1'b0;
        if (ms_tick && pulse_cnt != 16'h0000) pulse_cnt <= pulse_cnt - 16'h0001;
      end
    end
  end

  // door ajar counter and tamper arming
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ajar_cnt <= 8'h00;
      armed <= 1'b0;
      tamp_seen_q <= 1'b0;
      blink <= 9'h000;
    end else begin
      tamp_seen_q <= tamp_src;
      if (tamp_seen_q != tamp_src) armed <= 1'b1;
      if (!door_open || door_rise) ajar_cnt <= ajar_time;
      else if (sec_tick && ajar_cnt != 8'h00) ajar_cnt <= ajar_cnt - 8'h01;
      if (ms_tick) blink <= (blink == 9'(2 * `DAC_BEEP_HALF_MS - 1)) ? 9'h000 : blink + 9'h001;
    end
  end

  // alarm conditions and signalling timers, one per class
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_alarm
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          alarm[g] <= 1'b0;
          beep_act[g] <= 1'b0;
          sig_cnt[g] <= 8'h00;
        end else begin
          if (alarm_ev[g]) alarm[g] <= 1'b1; // set wins
          else if (alarm_clr[g] || (g < 2 && sec_tick && sig_cnt[g] == 8'h00)) alarm[g] <= 1'b0;
          if (alarm_ev[g] && sig_time[g] != 8'h00 && g != 0) begin
            beep_act[g] <= 1'b1;
            sig_cnt[g] <= sig_time[g];
          end else if (alarm_ev[g] && g == 0) begin
            sig_cnt[g] <= sig_time[g];
          end else if (cred_valid) begin
            beep_act[g] <= 1'b0;
          end else if (sec_tick && sig_cnt[g] != 8'h00) begin
            sig_cnt[g] <= sig_cnt[g] - 8'h01;
            if (sig_cnt[g] == 8'h01) beep_act[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // intrusion relay: status or pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ids_cnt <= 16'h0000;
      intrusion_system <= 1'b0;
    end else if (ids_mode && ids_pulse_mode) begin
      if (ids_request) ids_cnt <= 16'(ids_pulse_steps) * 16'(`DAC_IDS_STEP_MS);
      else if (ms_tick && ids_cnt != 16'h0000) ids_cnt <= ids_cnt - 16'h0001;
      intrusion_system <= (ids_cnt != 16'h0000);
    end else begin
      ids_cnt <= 16'h0000;
      intrusion_system <= ids_mode && ids_request; // active means disarmed
    end
  end

  // registered outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_release <= 1'b0;
      beeper <= 1'b0;
      alarm_out <= 1'b0;
      alarm_status <= 5'h00;
      invalid_signal <= 1'b0;
      inv_cnt <= 1'b0;
      reason_code <= 8'h00;
      cred_code <= '0;
      host_report <= 1'b0;
      ext_buzzer <= 1'b0;
      cfg_conflict <= 1'b0;
    end else begin
      lock_release <= next_lock;
      beeper <= next_beeper;
      alarm_out <= next_alarm_out;
      alarm_status <= alarm; // reads leave alarms alone
      invalid_signal <= cred_invalid;
      inv_cnt <= cred_invalid && |beep_act; // interrupt tone
      host_report <= any_read || host_open; // reads still reported
      cfg_conflict <= conflict;
      ext_buzzer <= entry && next_beeper;
      if (any_read) begin
        reason_code <= (entry && cred_ext) ? 8'(`DAC_REASON_EXT) : key_code;
        cred_code <= hid_tech ? hid_fmt : em_trunc;
      end
    end
  end

  // checks
  lock_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (st_pul && !perm && pulse_cnt != 16'h0000) |=> lock_release) else $error("pulse lock not held");
  no_conflict_a: assert property (@(posedge core_clk) disable iff (!rstn)
    conflict |=> cfg_conflict) else $error("conflict not flagged");
  perm_lock_a: assert property (@(posedge core_clk) disable iff (!rstn)
    perm |=> lock_release) else $error("permanent release lost");
  forced_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
    forced_ev |=> alarm[3]) else $error("forced alarm not set");
  tamper_arm_a: assert property (@(posedge core_clk) disable iff (!rstn)
    !armed |-> !tamper_ev) else $error("tamper before arming");
  ext_reason_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (any_read && entry && cred_ext) |=> reason_code == 8'hFF) else $error("bad reason code");
  silence_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (cred_valid && !(|alarm_ev)) |=> beep_act == 5'h00) else $error("beep not silenced");
  alarm_out_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (alarm == 5'h00) |=> !alarm_out) else $error("alarm output stuck");
  cov_open_c: cover property (@(posedge core_clk) open_act ##1 lock_release);
  cov_forced_c: cover property (@(posedge core_clk) forced_ev);
  cov_tamper_c: cover property (@(posedge core_clk) tamper_ev ##1 beeper);
endmodule : dac_ctrl

// file: test/dac_door_model.sv
// door leaf and contact model standing behind the lock relay output
`timescale 1ns/1ps
module dac_door_model (
  input wire logic core_clk,
  input wire logic lock_release,
  input wire logic auto_open,
  input wire logic force_open,
  output logic door_open
);
  logic [1:0] wait_cnt = 2'h0; // cycles the lock has been seen released
  logic pushed = 1'b0; // a person has pushed the door open
  // a visitor waits a few cycles after release, then stays in the doorway until told to leave
  always @(posedge core_clk) begin
    if (!auto_open) begin
      wait_cnt <= 2'h0;
      pushed <= 1'b0;
    end else if (wait_cnt == 2'h3) begin
      pushed <= 1'b1;
    end else if (lock_release) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
  // forcing stands for someone opening the leaf without any release
  assign door_open = force_open | pushed;
endmodule : dac_door_model

// file: test/dac_ctrl_bench.sv
// self-checking bench for the door access and alarm control top
`timescale 1ns/1ps
module dac_ctrl_bench;
  logic core_clk = 1'b0, rstn = 1'b0;
  logic [1:0] relay_style = 2'h0, second_input_mode = 2'h3, em_len_sel = 2'h2, wg_mode = 2'h1;
  logic [7:0] release_time = 8'h07, ajar_time = 8'h14, sig_time_tamper = 8'h1E, sig_time_forced = 8'h1E;
  logic [7:0] sig_time_ajar = 8'h00, sig_time_apb = 8'h05, sig_time_card = 8'h1E;
  logic [7:0] ids_pulse_steps = 8'h02, key_code = 8'h05;
  logic [15:0] pulse_width_ms = 16'h0001;
  logic beep_on_release = 1'b1, exit_enable = 1'b0, sched_enable = 1'b0, sched_valid = 1'b0;
  logic third_input_tamper = 1'b0, ids_pulse_mode = 1'b0, ids_request = 1'b0;
  logic cred_valid = 1'b0, cred_invalid = 1'b0, cred_ext = 1'b0, cred_alarm_flag = 1'b0, cred_duress = 1'b0;
  logic apb_time_block = 1'b0, apb_zone_block = 1'b0, host_open = 1'b0, exit_button = 1'b0;
  logic second_input = 1'b0, third_input = 1'b0, optical_tamper = 1'b0, hid_tech = 1'b0;
  logic [39:0] em_code_in = 40'hFFFFFFFFFF;
  logic [44:0] hid_raw = 45'h1FFFFFFFFFFF, cred_code;
  logic [5:0] hid_len = 6'h1A;
  logic door_open, lock_release, beeper, alarm_out, invalid_signal, host_report;
  logic intrusion_system, cfg_conflict, ext_buzzer, auto_open = 1'b0, force_open = 1'b0;
  logic [4:0] alarm_status;
  logic [7:0] reason_code;
  int num_errors = 0, n_checks = 0, cycles = 0;

  dac_ctrl dac_ctrl_inst (.core_clk, .rstn, .relay_style, .release_time, .pulse_width_ms, .beep_on_release,
    .exit_enable, .sched_enable, .sched_valid, .second_input_mode, .third_input_tamper, .ajar_time,
    .sig_time_tamper, .sig_time_forced, .sig_time_ajar, .sig_time_apb, .sig_time_card, .em_len_sel, .wg_mode,
    .ids_pulse_mode, .ids_pulse_steps, .ids_request, .key_code, .cred_valid, .cred_invalid, .cred_ext,
    .cred_alarm_flag, .cred_duress, .apb_time_block, .apb_zone_block, .host_open, .exit_button, .door_open,
    .second_input, .third_input, .optical_tamper, .em_code_in, .hid_tech, .hid_raw, .hid_len, .lock_release,
    .beeper, .alarm_out, .alarm_status, .invalid_signal, .reason_code, .cred_code, .host_report,
    .ext_buzzer, .intrusion_system, .cfg_conflict);
  dac_door_model dac_door_model_inst (.core_clk, .lock_release, .auto_open, .force_open, .door_open);

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  // hang guard: the pulse wait dominates the run, so 80k cycles is ample
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      $display("BAD %0t: run did not finish", $time);
      end_sim();
    end
  end

  // inputs move 5 ns after the edge so the design never sees a race
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : step

  task automatic chk(input logic [44:0] got, input logic [44:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle event: 0 valid read, 1 host request, 2 exit button, 3 invalid read
  task automatic fire(input int k);
    cred_valid = (k == 0);
    host_open = (k == 1);
    exit_button = (k == 2);
    cred_invalid = (k == 3);
    step(1);
    {cred_valid, host_open, exit_button, cred_invalid} = 4'h0;
  endtask : fire

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  initial begin
    repeat (8) @(posedge core_clk);
    #5 rstn = 1'b1;
    step(1);
    chk({lock_release, beeper, alarm_out, alarm_status}, 8'h00);
    step(1);
    // exit button ignored unless enabled, then a short relay pulse
    relay_style = 2'h2;
    fire(2);
    chk(lock_release, 1'b0);
    exit_enable = 1'b1;
    fire(2);
    // relay state settles one cycle after the open action
    step(1);
    chk(lock_release, 1'b1);
    step(10);
    chk(lock_release, 1'b1);
    for (int i = 0; i < 45000 && lock_release === 1'b1; i++) step(1);
    chk(lock_release, 1'b0);
    // standard release ends when the visitor opens the door
    relay_style = 2'h0;
    auto_open = 1'b1;
    fire(0);
    chk(host_report, 1'b1);
    step(1);
    chk({lock_release, beeper, ext_buzzer}, 3'h7);
    for (int i = 0; i < 20 && door_open !== 1'b1; i++) step(1);
    step(3);
    chk({lock_release, beeper, alarm_status[3]}, 3'h0);
    auto_open = 1'b0;
    step(2);
    // toggle holds until the next open action
    relay_style = 2'h1;
    fire(1);
    step(1);
    chk(lock_release, 1'b1);
    step(20);
    chk(lock_release, 1'b1);
    fire(1);
    step(1);
    chk(lock_release, 1'b0);
    // schedule release refused with toggle, honoured with standard
    sched_enable = 1'b1;
    sched_valid = 1'b1;
    step(2);
    chk({cfg_conflict, lock_release}, 2'h2);
    relay_style = 2'h0;
    step(2);
    chk({cfg_conflict, lock_release}, 2'h1);
    force_open = 1'b1;
    step(3);
    chk(alarm_status[3], 1'b0);
    force_open = 1'b0;
    step(2);
    sched_enable = 1'b0;
    step(3);
    // forced door, cleared by closing
    force_open = 1'b1;
    step(3);
    chk({alarm_status[3], alarm_out}, 2'h3);
    force_open = 1'b0;
    step(3);
    chk({alarm_status[3], alarm_out}, 2'h0);
    // handle contact excuses the opening
    second_input_mode = 2'h1;
    second_input = 1'b1;
    force_open = 1'b1;
    step(3);
    chk(alarm_status[3], 1'b0);
    force_open = 1'b0;
    second_input = 1'b0;
    second_input_mode = 2'h3;
    step(3);
    // a valid read during an alarm keeps it and still opens
    force_open = 1'b1;
    step(3);
    fire(0);
    step(1);
    chk({alarm_status[3], lock_release}, 2'h3);
    fire(3);
    chk({alarm_status[3], invalid_signal}, 2'h3);
    force_open = 1'b0;
    step(3);
    // time and zone antipassback never reach the alarm output
    for (int z = 0; z < 2; z++) begin
      apb_time_block = (z == 0);
      apb_zone_block = (z == 1);
      fire(0);
      {apb_time_block, apb_zone_block} = 2'h0;
      step(1);
      chk({alarm_status[1], alarm_out}, 2'h2);
    end
    // code length truncation and reason codes
    for (int s = 0; s < 3; s++) begin
      em_len_sel = s[1:0];
      cred_ext = (s == 0);
      fire(0);
      chk(cred_code, (45'h1 << (24 + 8 * s)) - 45'h1);
      chk(reason_code, (s == 0) ? 8'hFF : key_code);
    end
    cred_ext = 1'b0;
    hid_tech = 1'b1;
    fire(0);
    chk(cred_code, 45'h3FFFFFF);
    hid_len = 6'h00;
    fire(0);
    chk(cred_code, 45'h1FFFFFFFFFFF);
    // alarm flag and duress read
    cred_alarm_flag = 1'b1;
    cred_duress = 1'b1;
    fire(0);
    {cred_alarm_flag, cred_duress} = 2'h0;
    step(1);
    chk({alarm_status[0], alarm_out}, 2'h3);
    // intrusion relay in status style follows the request
    wg_mode = 2'h2;
    ids_request = 1'b1;
    step(3);
    chk(intrusion_system, 1'b1);
    ids_request = 1'b0;
    step(3);
    chk(intrusion_system, 1'b0);
    // first sensor change arms tamper, which trips one cycle later while the sensor stays active
    chk(alarm_status[4], 1'b0);
    optical_tamper = 1'b1;
    step(3);
    optical_tamper = 1'b0;
    step(3);
    optical_tamper = 1'b1;
    step(3);
    chk({alarm_status[4], beeper}, 2'h3);
    step(20);
    chk(beeper, 1'b1);
    end_sim();
  end
endmodule : dac_ctrl_bench
